// File: design/swac_pkg.sv
// Constants shared by the serial wait and acknowledge control block
package swac_pkg;

  // ----------------------------------------------------------------
  // Wait control register layout
  // ----------------------------------------------------------------
  localparam int          ACK_BIT_POS   = 3;
  localparam int          NO_WAIT_POS   = 2;
  localparam int          SEL_HI_POS    = 1;
  localparam int          SEL_LO_POS    = 0;
  localparam logic [3:0]  CTRL_RESET    = 4'h0;

  // ----------------------------------------------------------------
  // Wait timing select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  WAIT_NONE     = 2'h0;
  localparam logic [1:0]  WAIT_DATA     = 2'h1;
  localparam logic [1:0]  WAIT_ACK      = 2'h2;
  localparam logic [1:0]  WAIT_ADDR     = 2'h3;

  // ----------------------------------------------------------------
  // Clock counter values
  // ----------------------------------------------------------------
  localparam int          CNT_W         = 4;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam logic [3:0]  CNT_WRAP_TO   = 4'h1;
  localparam logic [3:0]  CNT_DATA      = 4'h8;
  localparam logic [3:0]  CNT_ACK       = 4'h9;

  // Counter step with wrap from the ack count back to one
  function automatic logic [3:0] swac_next_count(input logic [3:0] c);
    swac_next_count = (c == CNT_ACK) ? CNT_WRAP_TO : 4'(c + 4'h1);
  endfunction

endpackage

// File: design/swac_cnt_if.sv
// Interface between the wait controller and its clock counter
`timescale 1ns/100ps
`default_nettype none
interface swac_cnt_if;
  logic       advance;
  logic       clear;
  logic [3:0] count;

  modport ctrl (output advance, output clear, input count);
  modport cnt  (input advance, input clear, output count);
endinterface // swac_cnt_if
`default_nettype wire

// File: design/swac_pin_sync.sv
// Two-stage pin synchroniser with edge pulses
`timescale 1ns/100ps
`default_nettype none
module swac_pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Raw pins
  input  wire logic [WIDTH-1:0] din,
  // Synchronised view
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage;
  logic [WIDTH-1:0] prev;

  // Idle bus lines float high, so start from high
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta  <= '1;
      stage <= '1;
      prev  <= '1;
    end else begin
      meta  <= din;
      stage <= meta;
      prev  <= stage;
    end
  end

  assign level = stage;
  assign rise  = stage & ~prev;
  assign fall  = ~stage & prev;

endmodule // swac_pin_sync
`default_nettype wire

// File: design/swac_clk_counter.sv
// Shift clock counter, counts 1 to 9 and wraps to 1
`timescale 1ns/100ps
`default_nettype none
module swac_clk_counter
  import swac_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Control and count
  swac_cnt_if.cnt   cif
);

  logic [3:0] next_count;

  // Clear beats advance so a start mid-byte realigns the count
  assign next_count = cif.clear   ? CNT_ZERO :
                      cif.advance ? swac_next_count(cif.count) :
                                    cif.count;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cif.count <= CNT_ZERO;
    end else begin
      cif.count <= next_count;
    end
  end

endmodule // swac_clk_counter
`default_nettype wire

// File: design/swac_wait_ctrl.sv
// Serial wait and acknowledge control, top level
//
// Operation
// - Four-bit register: ack bit 3, no-wait flag 2, timing select 1..0.
// - Power-on reset and stop halt clear every register bit.
// - During wait, shift clock edges neither count nor shift.
// - Two-wire: wait at falling edge, count 8, 9, or 8 after start.
// - Serial I/O: data and ack wait park clock high; no address wait.
// - Two-wire slave drives clock pin low at the wait point.
// - Select zero never waits nor holds the clock line.
// - After release, wait recurs at the next matching count.
// - Address wait only at first count 8 after a start.
// - Software reads the no-wait flag to see wait state while a select is set.
// - Two-wire master holds its generated clock low at a wait point; a forced wait holds its current level.
// - Serial I/O internal clock parks generated clock high at a wait point; a forced wait holds its current level.
// - Serial I/O register write clears counter; wait follows written no-wait bit.
// - Serial I/O internal clock without select runs continuously.
// - Serial I/O external clock ignores clocks after wait point.
// - Writing zero to no-wait with a select set forces wait and halts generation.
// - Writing one releases wait; generated clock resumes where held.
// - Two-wire receive drives stored ack bit during each ack slot.
// - Two-wire transmit captures the receiver's ack into the bit.
// - Serial I/O leaves ack bit as a plain storage bit.
// - Counter starts at zero, wraps 9 to 1, clears on start.
// - Master select picks slave/master or external/internal clock.
`timescale 1ns/100ps
`default_nettype none
module swac_wait_ctrl
  import swac_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       stop_halt,
  // Register file access
  input  wire logic       reg_wr_en,
  input  wire logic [3:0] reg_wr_data,
  output logic      [3:0] reg_rd_data,
  // Mode selection
  input  wire logic       protocol_select,
  input  wire logic       clock_source_master_sel,
  input  wire logic       transmit_select,
  input  wire logic       int_clk_tick,
  // Shift clock pin
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  // Serial data pin
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Shift register strobes and status
  output logic            shift_in_pulse,
  output logic            shift_out_pulse,
  output logic      [3:0] clk_count,
  output logic            wait_active
);

  // ----------------------------------------------------------------
  // Pin synchronisation and counter
  // ----------------------------------------------------------------
  logic [1:0] pin_level;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;

  swac_cnt_if cif ();

  swac_pin_sync #(.WIDTH(2)) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .din      ({sda_in, scl_in}),
    .level    (pin_level),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  swac_clk_counter u_cnt (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .cif      (cif.cnt)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0] wait_sel;
  logic       wait_q;
  logic       ack_bit;
  logic       addr_armed;
  logic       gen_clk;
  logic       ack_slot;
  logic       proto_q;

  wire        clr_all   = sys_rst | stop_halt;
  wire        two_wire  = protocol_select;
  wire        gen_mode  = clock_source_master_sel;
  wire        scl_lvl   = pin_level[0];
  wire        sda_lvl   = pin_level[1];
  wire [3:0]  count     = cif.count;
  wire [3:0]  count_nx  = swac_next_count(count);

  // Stored wait only bites with a select set; zero select never waits
  wire        sel_any   = (wait_sel != WAIT_NONE);
  wire        wait_eff  = wait_q & sel_any;
  wire        run       = ~wait_eff;

  // ----------------------------------------------------------------
  // Shift clock edge source
  // ----------------------------------------------------------------
  wire        gen_tick  = gen_mode & int_clk_tick & run;
  wire        gen_rise  = gen_tick & ~gen_clk;
  wire        gen_fall  = gen_tick & gen_clk;
  wire        clk_rise  = gen_mode ? gen_rise : pin_rise[0];
  wire        clk_fall  = gen_mode ? gen_fall : pin_fall[0];
  wire        rise_run  = clk_rise & run;
  wire        fall_run  = clk_fall & run;

  wire        start_det = two_wire & pin_fall[1] & scl_lvl;
  wire        mode_chg  = (proto_q != protocol_select);
  wire        sio_write = reg_wr_en & ~two_wire;

  // ----------------------------------------------------------------
  // Wait point decode
  // ----------------------------------------------------------------
  wire [3:0]  wait_cnt  = (wait_sel == WAIT_ACK) ? CNT_ACK : CNT_DATA;
  wire        addr_ok   = (wait_sel != WAIT_ADDR) | addr_armed;
  wire        hit_2w    = two_wire & fall_run & sel_any &
                          (count == wait_cnt) & addr_ok;
  // Address wait is not a legal serial I/O setting, so it never hits
  wire        hit_sio   = ~two_wire & rise_run &
                          ((wait_sel == WAIT_DATA) |
                           (wait_sel == WAIT_ACK)) &
                          (count_nx == wait_cnt);
  wire        wait_hit  = hit_2w | hit_sio;

  wire        ack_cap   = two_wire & transmit_select & rise_run &
                          (count == CNT_DATA);
  wire        byte_bit  = ~two_wire | (count < CNT_DATA);

  // ----------------------------------------------------------------
  // Next values for pins and strobes
  // ----------------------------------------------------------------
  logic next_scl_oe;
  logic next_scl_out;

  always_comb begin
    next_scl_oe  = 1'b0;
    next_scl_out = 1'b0;
    if (two_wire && !gen_mode) begin
      next_scl_oe = wait_eff;
    end else if (two_wire) begin
      next_scl_oe = ~gen_clk;
    end else if (gen_mode) begin
      next_scl_oe  = 1'b1;
      next_scl_out = gen_clk;
    end
  end

  wire next_sda_oe = two_wire & ~transmit_select & ack_slot &
                     ~ack_bit;

  // ----------------------------------------------------------------
  // Counter control
  // ----------------------------------------------------------------
  assign cif.advance = rise_run;
  assign cif.clear   = start_det | sio_write | mode_chg |
                       stop_halt;

  // ----------------------------------------------------------------
  // Register and control state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (clr_all) begin
      wait_sel <= CTRL_RESET[SEL_HI_POS:SEL_LO_POS];
      wait_q   <= ~CTRL_RESET[NO_WAIT_POS];
    end else begin
      if (reg_wr_en) begin
        wait_sel <= reg_wr_data[SEL_HI_POS:SEL_LO_POS];
      end
      // A wait point hit in the write cycle still takes effect
      if (wait_hit) begin
        wait_q <= 1'b1;
      end else if (reg_wr_en) begin
        wait_q <= ~reg_wr_data[NO_WAIT_POS];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr_all) begin
      ack_bit <= CTRL_RESET[ACK_BIT_POS];
    end else if (ack_cap) begin
      ack_bit <= sda_lvl;
    end else if (reg_wr_en) begin
      ack_bit <= reg_wr_data[ACK_BIT_POS];
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr_all) begin
      addr_armed <= 1'b0;
    end else if (start_det) begin
      addr_armed <= 1'b1;
    end else if (hit_2w && wait_sel == WAIT_ADDR) begin
      addr_armed <= 1'b0;
    end
  end

  // Parked high so an idle internal clock looks like a released line
  always_ff @(posedge core_clk) begin
    if (clr_all) begin
      gen_clk <= 1'b1;
    end else if (gen_tick) begin
      gen_clk <= ~gen_clk;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr_all || !two_wire) begin
      ack_slot <= 1'b0;
    end else if (fall_run && count == CNT_DATA) begin
      ack_slot <= 1'b1;
    end else if (rise_run) begin
      ack_slot <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      proto_q         <= 1'b0;
      reg_rd_data     <= CTRL_RESET;
      scl_oe          <= 1'b0;
      scl_out         <= 1'b0;
      sda_oe          <= 1'b0;
      sda_out         <= 1'b0;
      shift_in_pulse  <= 1'b0;
      shift_out_pulse <= 1'b0;
      wait_active     <= 1'b0;
    end else begin
      proto_q         <= protocol_select;
      reg_rd_data     <= {ack_bit, ~wait_q, wait_sel};
      scl_oe          <= next_scl_oe;
      scl_out         <= next_scl_out;
      sda_oe          <= next_sda_oe;
      sda_out         <= 1'b0;
      shift_in_pulse  <= rise_run & byte_bit;
      shift_out_pulse <= fall_run & byte_bit;
      wait_active     <= wait_eff;
    end
  end

  assign clk_count = cif.count;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_count_hold: assert property (
    wait_eff && !cif.clear |=> $stable(cif.count))
    else $error("counter moved during wait");

  chk_count_wrap: assert property (
    cif.advance && cif.count == CNT_ACK && !cif.clear
    |=> cif.count == CNT_WRAP_TO)
    else $error("counter did not wrap to one");

  chk_data_wait: assert property (
    two_wire && wait_sel == WAIT_DATA && fall_run &&
    cif.count == CNT_DATA && !stop_halt |=> wait_q)
    else $error("data wait not entered");

  chk_zero_sel: assert property (
    wait_sel == WAIT_NONE && !clr_all |=> !wait_active)
    else $error("wait with no select");

  chk_slave_hold: assert property (
    two_wire && !gen_mode && wait_eff |=> scl_oe && !scl_out)
    else $error("slave did not hold clock low");

  chk_shift_gate: assert property (
    wait_eff |=> !shift_in_pulse && !shift_out_pulse)
    else $error("shift strobe during wait");

  chk_sio_clear: assert property (
    reg_wr_en && !two_wire |=> cif.count == CNT_ZERO)
    else $error("serial write did not clear counter");

  chk_release_flag: assert property (
    reg_wr_en && reg_wr_data[NO_WAIT_POS] && !wait_hit && !stop_halt
    |=> ##1 reg_rd_data[NO_WAIT_POS])
    else $error("no-wait flag not set after release");

  chk_ack_capture: assert property (
    ack_cap && !stop_halt |=> ack_bit == $past(sda_lvl))
    else $error("ack not captured");

  chk_ack_drive: assert property (
    two_wire && !transmit_select && ack_slot && !ack_bit
    |=> sda_oe && !sda_out)
    else $error("ack not driven in slot");

  chk_clk_park: assert property (
    gen_mode && wait_eff && !clr_all |=> $stable(gen_clk))
    else $error("generated clock moved in wait");

endmodule // swac_wait_ctrl
`default_nettype wire

// File: test/swac_bus_peer.sv
// Bus or serial peer that makes the link clock and data bits
`timescale 1ns/100ps
`default_nettype none
module swac_bus_peer (
  // Alignment clock
  input  wire logic core_clk,
  // Resolved lines
  input  wire logic scl_line,
  input  wire logic sda_line,
  // Open-drain drives, high means released
  output logic      scl_drv,
  output logic      sda_drv
);
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // Off the core edge so pin changes never race it
  task automatic align();
    @(posedge core_clk);
    #13;
  endtask

  task automatic start_cond();
    align();
    sda_drv = 1'b1;
    #100 scl_drv = 1'b1;
    #200 sda_drv = 1'b0;
    #200;
  endtask

  task automatic fall();
    align();
    scl_drv = 1'b0;
    #200;
  endtask

  // One clock of 400 ns when calls follow back to back; a stretched
  // clock is waited on for a bounded time
  task automatic bit_cycle(input logic b, output logic seen);
    int i;
    align();
    scl_drv = 1'b0;
    sda_drv = b;
    #200 scl_drv = 1'b1;
    for (i = 0; i < 100 && scl_line !== 1'b1; i++) #50;
    seen = sda_line;
    #150;
  endtask
endmodule // swac_bus_peer
`default_nettype wire

// File: test/swac_wait_ctrl_tb.sv
// Self-checking bench for the serial wait and acknowledge control
`timescale 1ns/100ps
`default_nettype none
module swac_wait_ctrl_tb;
  logic       core_clk, sys_rst, stop_halt, reg_wr_en;
  logic [3:0] reg_wr_data, reg_rd_data, clk_count;
  logic       protocol_select, clock_source_master_sel, transmit_select;
  logic       int_clk_tick = 1'b0;
  logic       scl_out, scl_oe, sda_out, sda_oe;
  logic       shift_in_pulse, shift_out_pulse, wait_active, seen;
  logic       scl_drv, sda_drv;
  wire        scl_line = scl_drv & (scl_oe ? scl_out : 1'b1);
  wire        sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
  int         n_fail, n_compared;
  int         cyc = 0, n_shift = 0, tick_div = 0;

  swac_wait_ctrl uut (.core_clk(core_clk), .sys_rst(sys_rst),
    .stop_halt(stop_halt), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .protocol_select(protocol_select),
    .clock_source_master_sel(clock_source_master_sel),
    .transmit_select(transmit_select), .int_clk_tick(int_clk_tick),
    .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .shift_in_pulse(shift_in_pulse), .shift_out_pulse(shift_out_pulse),
    .clk_count(clk_count), .wait_active(wait_active));

  swac_bus_peer peer (.core_clk(core_clk), .scl_line(scl_line),
    .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------------
  // Tick source, shift pulse tally, watchdog
  // ------------------------------------------------------------------
  always @(posedge core_clk) begin
    tick_div <= tick_div + 1;
    int_clk_tick <= (tick_div[1:0] == 2'h3);
    if (shift_in_pulse === 1'b1 || shift_out_pulse === 1'b1) begin
      n_shift <= n_shift + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [3:0] seen_v, input logic [3:0] exp);
    n_compared++;
    if (seen_v !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen_v, exp);
    end
  endtask

  // Ends on a falling edge so outputs are settled
  task automatic wcyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic reg_wr(input logic [3:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_wr_data <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    wcyc(2);
  endtask

  task automatic wait_hit();
    for (int i = 0; i < 400 && wait_active !== 1'b1; i++) begin
      @(negedge core_clk);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    int k;
    sys_rst = 1'b1;
    stop_halt = 1'b0;
    reg_wr_en = 1'b0;
    reg_wr_data = 4'h0;
    protocol_select = 1'b1;
    clock_source_master_sel = 1'b0;
    transmit_select = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    wcyc(1);
    check(reg_rd_data, 4'h0);
    check({3'h0, wait_active}, 4'h0);
    // Slave receive, address wait after a start
    reg_wr(4'h7);
    peer.start_cond();
    repeat (8) peer.bit_cycle(1'b1, seen);
    peer.fall();
    wcyc(4);
    check(clk_count, 4'h8);
    check({wait_active, scl_oe, sda_oe, scl_line}, 4'he);
    check({2'h0, scl_out, sda_out}, 4'h0);
    check(reg_rd_data, 4'h3);
    reg_wr(4'h7);
    peer.bit_cycle(1'b1, seen);
    check({3'h0, seen}, 4'h0);
    repeat (8) peer.bit_cycle(1'b1, seen);
    peer.fall();
    wcyc(4);
    check({clk_count[3:1], wait_active}, 4'h8);
    $display("test address_wait done");
    // Data wait recurs every byte, ack stored as one
    reg_wr(4'hd);
    peer.bit_cycle(1'b1, seen);
    check({3'h0, seen}, 4'h1);
    for (k = 0; k < 2; k++) begin
      repeat (8) peer.bit_cycle(1'b1, seen);
      peer.fall();
      wcyc(4);
      check({wait_active, sda_oe, clk_count[3:2]}, 4'ha);
      reg_wr(4'hd);
      peer.bit_cycle(1'b1, seen);
    end
    $display("test data_wait done");
    // Forced wait, release, zero select
    reg_wr(4'h9);
    check({wait_active, reg_rd_data[2:0]}, 4'h9);
    reg_wr(4'hd);
    check({wait_active, reg_rd_data[2:0]}, 4'h5);
    reg_wr(4'h0);
    repeat (9) peer.bit_cycle(1'b0, seen);
    peer.fall();
    wcyc(4);
    check({wait_active, scl_oe, 2'h0}, 4'h0);
    $display("test forced_wait done");
    // Transmit: ack wait, receiver ack captured
    @(posedge core_clk);
    transmit_select <= 1'b1;
    reg_wr(4'he);
    peer.start_cond();
    repeat (8) peer.bit_cycle(1'b1, seen);
    peer.bit_cycle(1'b0, seen);
    peer.fall();
    wcyc(4);
    check(clk_count, 4'h9);
    check({wait_active, scl_oe, 2'h0}, 4'hc);
    check(reg_rd_data, 4'h2);
    $display("test transmit_ack done");
    // Serial I/O, external clock; address wait never chosen here
    @(posedge core_clk);
    protocol_select <= 1'b0;
    transmit_select <= 1'b0;
    reg_wr(4'h5);
    check(clk_count, 4'h0);
    repeat (8) peer.bit_cycle(1'b1, seen);
    wcyc(4);
    k = n_shift;
    repeat (3) peer.bit_cycle(1'b1, seen);
    wcyc(4);
    check(clk_count, 4'h8);
    check({wait_active, scl_oe, 2'h0}, 4'h8);
    check(4'(n_shift - k), 4'h0);
    reg_wr(4'he);
    check(clk_count, 4'h0);
    repeat (10) peer.bit_cycle(1'b0, seen);
    wcyc(4);
    check(clk_count, 4'h9);
    check(reg_rd_data, 4'ha);
    @(posedge core_clk);
    stop_halt <= 1'b1;
    @(posedge core_clk);
    stop_halt <= 1'b0;
    wcyc(2);
    check(reg_rd_data, 4'h0);
    check(clk_count, 4'h0);
    $display("test serial_external done");
    // Serial I/O, internal clock
    @(posedge core_clk);
    clock_source_master_sel <= 1'b1;
    reg_wr(4'h5);
    wait_hit();
    wcyc(2);
    check(clk_count, 4'h8);
    check({wait_active, scl_oe, scl_out, 1'b0}, 4'he);
    reg_wr(4'h4);
    k = n_shift;
    wcyc(200);
    check({3'h0, wait_active}, 4'h0);
    check({3'h0, (n_shift - k) > 40}, 4'h1);
    reg_wr(4'h1);
    k = n_shift;
    wcyc(100);
    check({wait_active, 3'h0}, 4'h8);
    check(4'(n_shift - k), 4'h0);
    reg_wr(4'h5);
    wait_hit();
    wcyc(2);
    check({wait_active, clk_count[3:1]}, 4'hc);
    $display("test serial_internal done");
    // Two-wire master holds its clock low
    @(posedge core_clk);
    protocol_select <= 1'b1;
    reg_wr(4'h5);
    wait_hit();
    wcyc(2);
    check(clk_count, 4'h8);
    check({wait_active, scl_oe, scl_line, 1'b0}, 4'hc);
    $display("test master_wait done");
    test_done();
  end
endmodule // swac_wait_ctrl_tb
`default_nettype wire
